/* fpe_pkg.sv */
// Constants, field layout and command words for the flash program/erase port
package fpe_pkg;
   localparam logic [23:0] IO_ADDR_ATTR0  = 24'h0ffff9;
   localparam logic [23:0] IO_ADDR_BUSCTL = 24'hfffffb;
   localparam logic [23:0] IO_ADDR_OPMODE = 24'hfffffc;
   localparam logic [23:0] ATTR0_RST      = 24'h000000;
   localparam logic [23:0] BUSCTL_RST     = 24'h000000;
   localparam logic [23:0] OPMODE_RST     = 24'h000000;
   localparam int ATTR_TYPE_LSB  = 0;
   localparam logic [1:0] ATTR_TYPE_ASYNC = 2'h1;
   localparam int ATTR_POL_BIT   = 2;
   localparam int ATTR_PSP_BIT   = 3;
   localparam int ATTR_XSP_BIT   = 4;
   localparam int ATTR_YSP_BIT   = 5;
   localparam int ATTR_SWAP_BIT  = 6;
   localparam int ATTR_PACK_BIT  = 7;
   localparam int ATTR_NCMP_LSB  = 8;
   localparam int ATTR_CMPV_LSB  = 12;
   localparam int WS0_LSB        = 0;
   localparam int WS1_LSB        = 5;
   localparam int WS2_LSB        = 10;
   localparam int WS3_LSB        = 13;
   localparam int WSDEF_LSB      = 16;
   localparam int BUS_STATE_BIT  = 21;
   localparam int LOCK_HOLD_BIT  = 22;
   localparam int REQ_HOLD_BIT   = 23;
   localparam int EXT_DIS_BIT    = 4;
   localparam int TA_SYNC_BIT    = 11;
   localparam int BB_SLOW_BIT    = 12;
   localparam int PRIO_DIS_BIT   = 14;
   localparam logic [23:0] BANK_BASE_DEF = 24'hc00000;
   localparam logic [23:0] UNLOCK1_ADDR  = 24'h005555;
   localparam logic [23:0] UNLOCK2_ADDR  = 24'h002aaa;
   localparam logic [23:0] UNLOCK1_DATA  = 24'haaaaaa;
   localparam logic [23:0] UNLOCK2_DATA  = 24'h555555;
   localparam logic [23:0] PROG_CMD      = 24'ha0a0a0;
   localparam logic [23:0] ERASE_SETUP   = 24'h808080;
   localparam logic [23:0] ERASE_CMD     = 24'h303030;
   localparam logic [23:0] ERASED_WORD   = 24'hffffff;
   localparam int SECTOR_SHIFT   = 16;
   localparam int SECTOR_IDX_W   = 3;
   localparam logic [2:0] PROG_LAST_STEP  = 3'h4;
   localparam logic [2:0] ERASE_LAST_STEP = 3'h6;
   localparam logic [5:0] AUTO_WAIT      = 6'h01;
   localparam logic [1:0] SYNC_SETTLE    = 2'h3;
   typedef enum logic [1:0] {SPACE_P, SPACE_X, SPACE_Y} fpe_space_type;
   typedef enum logic {OP_PROGRAM, OP_ERASE} fpe_op_type;
   typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_CHECK, ST_RELEASE} fpe_state_type;
endpackage

/* fpe_flash_port.sv */
// Flash program/erase sequencer with attribute decode and wait-state control
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_port #(
   parameter logic [23:0] BANK_BASE = fpe_pkg::BANK_BASE_DEF
) (
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   input  wire logic [23:0]           ioAddr,
   input  wire logic                  ioWr,
   input  wire logic                  ioRd,
   input  wire logic [23:0]           ioWdata,
   output logic      [23:0]           ioRdata,
   input  wire logic                  cmdStart,
   input  wire fpe_pkg::fpe_op_type    cmdOp,
   input  wire fpe_pkg::fpe_space_type cmdSpace,
   input  wire logic [23:0]           cmdAddr,
   input  wire logic [23:0]           cmdData,
   output logic                       seqBusy,
   output logic                       seqDone,
   output logic                       seqRefused,
   output logic      [23:0]           extAddr,
   input  wire logic [23:0]           extDataIn,
   output logic      [23:0]           extDataOut,
   output logic                       extDataOeN,
   output logic                       extWrN,
   output logic                       extRdN,
   output logic                       attributePinZero,
   input  wire logic                  transferAckInputN,
   output logic                       busBusyOutputN
);
   logic [23:0] attrReg, attrNext, busCtlReg, busCtlNext, opModeReg, opModeNext;
   logic        attrWrittenReg, attrWrittenNext;
   logic [23:0] ioRdataNext;
   logic        taS1Reg, taS2Reg, taS3Reg, taStableReg, taStableNext;
   logic [23:0] dS1Reg, dS2Reg, dS3Reg, dStableReg, dStableNext;
   logic        dAgree;
   fpe_pkg::fpe_state_type stateReg, stateNext;
   fpe_pkg::fpe_op_type    opReg, opNext;
   fpe_pkg::fpe_space_type spaceReg, spaceNext;
   logic [2:0]  stepReg, stepNext, launchStep;
   logic [23:0] addrReg, addrNext, dataReg, dataNext;
   logic [5:0]  waitReg, waitNext;
   logic [1:0]  chkReg, chkNext;
   logic        readReg, readNext, doLaunch, hit, bbHoldReg, bbHoldNext;
   logic [23:0] phys, extAddrNext, extDataOutNext;
   logic        extDataOeNNext, extWrNNext, extRdNNext, attrPinNext, busyNNext;
   logic        seqDoneNext, seqRefusedNext, seqBusyNext;

   // Top address bits compared against the stored value, per enabled space
   function automatic logic attrHit(input logic [23:0] a, input logic [23:0] r, input logic [1:0] sp);
      logic hitV;
      hitV = (sp == 2'(fpe_pkg::SPACE_P)) ? r[fpe_pkg::ATTR_PSP_BIT] :
             (sp == 2'(fpe_pkg::SPACE_X)) ? r[fpe_pkg::ATTR_XSP_BIT] : r[fpe_pkg::ATTR_YSP_BIT];
      for (int i = 0; i < 12; i++)
      begin
         if (i < int'(r[fpe_pkg::ATTR_NCMP_LSB +: 4]) && a[23-i] != r[23-i])
         begin
            hitV = 1'b0;
         end
      end
      return hitV;
   endfunction

   // Bank-relative offset of each step of the sequence
   function automatic logic [23:0] stepOffset(input logic [2:0] s, input logic er, input logic [23:0] a);
      logic [23:0] sector;
      sector = 24'(a[fpe_pkg::SECTOR_SHIFT +: fpe_pkg::SECTOR_IDX_W]) << fpe_pkg::SECTOR_SHIFT;
      case (s)
         3'h0, 3'h2: stepOffset = fpe_pkg::UNLOCK1_ADDR;
         3'h1:       stepOffset = fpe_pkg::UNLOCK2_ADDR;
         3'h3:       stepOffset = er ? fpe_pkg::UNLOCK1_ADDR : a;
         3'h4:       stepOffset = er ? fpe_pkg::UNLOCK2_ADDR : a;
         default:    stepOffset = sector;
      endcase
   endfunction

   // Command words already carry the byte on every lane
   function automatic logic [23:0] stepData(input logic [2:0] s, input logic er, input logic [23:0] d);
      case (s)
         3'h0:    stepData = fpe_pkg::UNLOCK1_DATA;
         3'h1:    stepData = fpe_pkg::UNLOCK2_DATA;
         3'h2:    stepData = er ? fpe_pkg::ERASE_SETUP : fpe_pkg::PROG_CMD;
         3'h3:    stepData = er ? fpe_pkg::UNLOCK1_DATA : d;
         3'h4:    stepData = fpe_pkg::UNLOCK2_DATA;
         default: stepData = fpe_pkg::ERASE_CMD;
      endcase
   endfunction

   // Register file
   always_comb
   begin
      attrNext = attrReg;
      busCtlNext = busCtlReg;
      opModeNext = opModeReg;
      attrWrittenNext = attrWrittenReg;
      ioRdataNext = ioRdata;
      if (ioWr)
      begin
         // Pack, hold and priority bits are stored for software only
         if (ioAddr == fpe_pkg::IO_ADDR_ATTR0)
         begin
            attrNext = ioWdata;
            attrWrittenNext = 1'b1;
         end
         if (ioAddr == fpe_pkg::IO_ADDR_BUSCTL)
         begin
            busCtlNext = ioWdata;
            busCtlNext[fpe_pkg::BUS_STATE_BIT] = 1'b0;
         end
         if (ioAddr == fpe_pkg::IO_ADDR_OPMODE)
         begin
            opModeNext = ioWdata;
         end
      end
      if (ioRd)
      begin
         case (ioAddr)
            fpe_pkg::IO_ADDR_ATTR0:  ioRdataNext = attrReg;
            // Invert before widening, or the upper hold bits read back as ones
            fpe_pkg::IO_ADDR_BUSCTL: ioRdataNext = busCtlReg | (24'({~busBusyOutputN}) << fpe_pkg::BUS_STATE_BIT);
            fpe_pkg::IO_ADDR_OPMODE: ioRdataNext = opModeReg;
            default:                 ioRdataNext = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         attrReg <= fpe_pkg::ATTR0_RST;
         busCtlReg <= fpe_pkg::BUSCTL_RST;
         opModeReg <= fpe_pkg::OPMODE_RST;
         attrWrittenReg <= 1'b0;
         ioRdata <= 24'h000000;
      end
      else if (clkEn)
      begin
         attrReg <= attrNext;
         busCtlReg <= busCtlNext;
         opModeReg <= opModeNext;
         attrWrittenReg <= attrWrittenNext;
         ioRdata <= ioRdataNext;
      end
   end

   // Pin synchronisers; only stages two and three are compared
   assign dAgree = (dS2Reg == dS3Reg);
   always_comb
   begin
      taStableNext = (taS2Reg == taS3Reg) ? taS3Reg : taStableReg;
      dStableNext = dAgree ? dS3Reg : dStableReg;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         {taS1Reg, taS2Reg, taS3Reg, taStableReg} <= 4'hf;
         {dS1Reg, dS2Reg, dS3Reg, dStableReg} <= 96'h0;
      end
      else if (clkEn)
      begin
         {taS1Reg, taS2Reg, taS3Reg} <= {transferAckInputN, taS1Reg, taS2Reg};
         {dS1Reg, dS2Reg, dS3Reg} <= {extDataIn, dS1Reg, dS2Reg};
         taStableReg <= taStableNext;
         dStableReg <= dStableNext;
      end
   end

   // Sequencer and external bus
   always_comb
   begin
      stateNext = stateReg;
      opNext = opReg;
      spaceNext = spaceReg;
      stepNext = stepReg;
      addrNext = addrReg;
      dataNext = dataReg;
      waitNext = waitReg;
      chkNext = chkReg;
      readNext = readReg;
      bbHoldNext = 1'b0;
      extAddrNext = extAddr;
      extDataOutNext = extDataOut;
      extDataOeNNext = extDataOeN;
      extWrNNext = extWrN;
      extRdNNext = extRdN;
      attrPinNext = attributePinZero;
      busyNNext = busBusyOutputN;
      seqDoneNext = 1'b0;
      seqRefusedNext = 1'b0;
      doLaunch = 1'b0;
      launchStep = stepReg;
      case (stateReg)
         fpe_pkg::ST_IDLE:
         begin
            busyNNext = ~bbHoldReg;
            if (cmdStart && opModeReg[fpe_pkg::EXT_DIS_BIT])
            begin
               seqRefusedNext = 1'b1;
            end
            else if (cmdStart)
            begin
               opNext = cmdOp;
               spaceNext = cmdSpace;
               addrNext = cmdAddr;
               dataNext = cmdData;
               doLaunch = 1'b1;
               launchStep = 3'h0;
            end
         end
         fpe_pkg::ST_STROBE:
         begin
            if (waitReg != 6'h00)
            begin
               waitNext = waitReg - 6'h01;
            end
            else if (!opModeReg[fpe_pkg::TA_SYNC_BIT] || !taStableReg)
            begin
               if (readReg)
               begin
                  chkNext = fpe_pkg::SYNC_SETTLE;
                  stateNext = fpe_pkg::ST_CHECK;
               end
               else
               begin
                  extWrNNext = 1'b1;
                  extDataOeNNext = 1'b1;
                  stateNext = fpe_pkg::ST_RELEASE;
               end
            end
         end
         fpe_pkg::ST_CHECK:
         begin
            // Read strobe stays low until the synchronised word has settled
            if (chkReg != 2'h0)
            begin
               chkNext = chkReg - 2'h1;
            end
            else if (dAgree)
            begin
               extRdNNext = 1'b1;
               if (dStableNext == ((opReg == fpe_pkg::OP_ERASE) ? fpe_pkg::ERASED_WORD : dataReg))
               begin
                  seqDoneNext = 1'b1;
                  bbHoldNext = opModeReg[fpe_pkg::BB_SLOW_BIT];
                  stateNext = fpe_pkg::ST_IDLE;
               end
               else
               begin
                  stateNext = fpe_pkg::ST_RELEASE;
               end
            end
         end
         fpe_pkg::ST_RELEASE:
         begin
            doLaunch = 1'b1;
            launchStep = readReg ? stepReg : stepReg + 3'h1;
         end
         default:
         begin
            stateNext = fpe_pkg::ST_IDLE;
         end
      endcase
      phys = BANK_BASE + stepOffset(launchStep, opNext == fpe_pkg::OP_ERASE, addrNext);
      hit = attrHit(phys, attrReg, 2'(spaceNext)) &&
            attrReg[fpe_pkg::ATTR_TYPE_LSB +: 2] == fpe_pkg::ATTR_TYPE_ASYNC;
      if (doLaunch)
      begin
         stepNext = launchStep;
         readNext = launchStep == ((opNext == fpe_pkg::OP_ERASE) ? fpe_pkg::ERASE_LAST_STEP : fpe_pkg::PROG_LAST_STEP);
         extAddrNext = (hit && attrReg[fpe_pkg::ATTR_SWAP_BIT]) ? {phys[7:0], phys[15:0]} : phys;
         extDataOutNext = stepData(launchStep, opNext == fpe_pkg::OP_ERASE, dataNext);
         extDataOeNNext = readNext;
         extWrNNext = readNext;
         extRdNNext = ~readNext;
         attrPinNext = attrWrittenReg ? (hit == attrReg[fpe_pkg::ATTR_POL_BIT]) : 1'b1;
         waitNext = (hit ? {1'b0, busCtlReg[fpe_pkg::WS0_LSB +: 5]} : {1'b0, busCtlReg[fpe_pkg::WSDEF_LSB +: 5]})
                    + fpe_pkg::AUTO_WAIT;
         busyNNext = 1'b0;
         stateNext = fpe_pkg::ST_STROBE;
      end
      seqBusyNext = stateNext != fpe_pkg::ST_IDLE;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         stateReg <= fpe_pkg::ST_IDLE;
         opReg <= fpe_pkg::OP_PROGRAM;
         spaceReg <= fpe_pkg::SPACE_P;
         {stepReg, addrReg, dataReg, waitReg, chkReg, readReg, bbHoldReg} <= 61'h0;
         {extAddr, extDataOut} <= 48'h0;
         {extDataOeN, extWrN, extRdN, attributePinZero, busBusyOutputN} <= 5'h1f;
         {seqDone, seqRefused, seqBusy} <= 3'h0;
      end
      else if (clkEn)
      begin
         stateReg <= stateNext;
         opReg <= opNext;
         spaceReg <= spaceNext;
         {stepReg, addrReg, dataReg, waitReg, chkReg, readReg, bbHoldReg} <=
            {stepNext, addrNext, dataNext, waitNext, chkNext, readNext, bbHoldNext};
         {extAddr, extDataOut} <= {extAddrNext, extDataOutNext};
         {extDataOeN, extWrN, extRdN, attributePinZero, busBusyOutputN} <=
            {extDataOeNNext, extWrNNext, extRdNNext, attrPinNext, busyNNext};
         {seqDone, seqRefused, seqBusy} <= {seqDoneNext, seqRefusedNext, seqBusyNext};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   pin_reset_held_a: assert property (!attrWrittenReg |-> attributePinZero)
      else $error("attribute pin dropped before first register write");
   ext_disable_a: assert property (clkEn && cmdStart && stateReg == fpe_pkg::ST_IDLE
      && opModeReg[fpe_pkg::EXT_DIS_BIT] |=> seqRefused && extWrN)
      else $error("command not refused while bus disabled");
   prog_unlock_a: assert property (stateReg == fpe_pkg::ST_STROBE && stepReg == 3'h0 |->
      extAddr == BANK_BASE + fpe_pkg::UNLOCK1_ADDR && extDataOut == fpe_pkg::UNLOCK1_DATA)
      else $error("first unlock write wrong");
   prog_command_a: assert property (stateReg == fpe_pkg::ST_STROBE && stepReg == 3'h2 |->
      extDataOut == ((opReg == fpe_pkg::OP_ERASE) ? fpe_pkg::ERASE_SETUP : fpe_pkg::PROG_CMD))
      else $error("third command word wrong");
   erase_sector_a: assert property (stateReg == fpe_pkg::ST_STROBE && stepReg == 3'h5
      && !attrReg[fpe_pkg::ATTR_SWAP_BIT] |-> extAddr[15:0] == BANK_BASE[15:0] && extDataOut == fpe_pkg::ERASE_CMD)
      else $error("erase command not at sector base");
   prog_done_a: assert property (seqDone && opReg == fpe_pkg::OP_PROGRAM |-> $past(dStableNext) == dataReg)
      else $error("program finished without matching read");
   erase_done_a: assert property (seqDone && opReg == fpe_pkg::OP_ERASE |-> $past(dStableNext) == fpe_pkg::ERASED_WORD)
      else $error("erase finished before all ones");
   auto_wait_a: assert property ($fell(extWrN) |=> !extWrN)
      else $error("write strobe shorter than two cycles");
   bus_status_a: assert property (ioRd && ioAddr == fpe_pkg::IO_ADDR_BUSCTL && clkEn |=>
      ioRdata[fpe_pkg::BUS_STATE_BIT] == $past(~busBusyOutputN))
      else $error("bus state status bit wrong");
   prog_done_c: cover property (seqDone && opReg == fpe_pkg::OP_PROGRAM);
   erase_done_c: cover property (seqDone && opReg == fpe_pkg::OP_ERASE);
   refused_c: cover property (seqRefused);
   poll_retry_c: cover property (stateReg == fpe_pkg::ST_CHECK ##1 stateReg == fpe_pkg::ST_RELEASE);
endmodule
`default_nettype wire

/* fpe_dummy_unused.sv */
// Intentionally empty companion file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* fpe_flash_model.sv */
// Behavioural model of the 24-bit flash bank: command decode, program, sector erase, polling
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model (
   input  wire logic        core_clk,
   input  wire logic [23:0] extAddr,
   input  wire logic [23:0] extDataOut,
   input  wire logic        extDataOeN,
   input  wire logic        extWrN,
   input  wire logic        extRdN,
   input  wire logic        attributePinZero,
   output logic      [23:0] extDataIn
);
   logic [23:0] mem [524288];
   logic [23:0] wrAddr [$];
   logic [23:0] wrData [$];
   logic        wrPin [$];
   int          wrLen [$];
   int          busyCycles = 4;
   int          busyLeft = 0;
   int          step = 0;
   int          lowCnt = 0;
   logic        wrPrev = 1'b1;
   logic [18:0] idx;
   logic [14:0] ofs;
   // Attribute pin acts as the top flash address line
   assign idx = {attributePinZero, extAddr[17:0]};
   assign ofs = extAddr[14:0];
   initial
   begin
      foreach (mem[i])
         mem[i] = 24'hffffff;
      extDataIn = 24'h3c3c3c;
   end
   always @(posedge core_clk)
   begin
      if (busyLeft > 0)
         busyLeft--;
      if (!extWrN)
      begin
         if (wrPrev)
         begin
            wrAddr.push_back(extAddr);
            wrData.push_back(extDataOut);
            wrPin.push_back(attributePinZero);
            lowCnt = 0;
            // Whole replicated words only; offsets relative to the bank
            case (step)
               0, 4: step = (ofs == 15'h5555 && extDataOut == 24'haaaaaa) ? step + 1 : 0;
               1, 5: step = (ofs == 15'h2aaa && extDataOut == 24'h555555) ? step + 1 : 0;
               2: step = (ofs != 15'h5555) ? 0 : (extDataOut == 24'ha0a0a0) ? 3 :
                         (extDataOut == 24'h808080) ? 4 : 0;
               3:
               begin
                  // Programming can only clear bits
                  mem[idx] = mem[idx] & extDataOut;
                  busyLeft = busyCycles;
                  step = 0;
               end
               default:
               begin
                  if (extDataOut == 24'h303030)
                     for (int i = 0; i < 65536; i++)
                        mem[{idx[18:16], 16'(i)}] = 24'hffffff;
                  busyLeft = busyCycles;
                  step = 0;
               end
            endcase
         end
         lowCnt++;
      end
      else if (!wrPrev)
         wrLen.push_back(lowCnt);
      wrPrev = extWrN;
      // Busy answers the complement; a released bus toggles every cycle
      extDataIn <= (!extRdN && extDataOeN) ? ((busyLeft > 0) ? ~mem[idx] : mem[idx]) : ~extDataIn;
   end
endmodule
`default_nettype wire

/* flash_program_erase_port_tb_top.sv */
// Self-checking testbench for the flash program/erase port
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_port_tb_top;
   localparam logic [23:0] Base = 24'hc00000;
   localparam logic [23:0] Aar  = 24'h0ffff9;
   localparam logic [23:0] Bus_wait_control  = 24'hfffffb;
   localparam logic [23:0] Operating_mode_reg  = 24'hfffffc;
   logic                   core_clk = 1'b0;
   logic                   sys_rst = 1'b1;
   logic [23:0]            ioAddr = 24'h000000;
   logic                   ioWr = 1'b0;
   logic                   ioRd = 1'b0;
   logic [23:0]            ioWdata = 24'h000000;
   logic                   cmdStart = 1'b0;
   fpe_pkg::fpe_op_type    cmdOp = fpe_pkg::OP_PROGRAM;
   fpe_pkg::fpe_space_type cmdSpace = fpe_pkg::SPACE_P;
   logic [23:0]            cmdAddr = 24'h000000;
   logic [23:0]            cmdData = 24'h000000;
   logic                   taN = 1'b0;
   logic                   slowRel = 1'b0;
   logic                   seqBusy;
   logic [23:0]            ioRdata, extAddr, extDataIn, extDataOut;
   logic                   seqDone, seqRefused, extDataOeN, extWrN, extRdN, attributePinZero, busBusyOutputN;
   int                     badCount = 0;
   int                     checkCount = 0;
   int                     cycles = 0;
   int                     defLen = 2;
   fpe_flash_port #(.BANK_BASE(Base)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
      .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata),
      .cmdStart(cmdStart), .cmdOp(cmdOp), .cmdSpace(cmdSpace), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .seqBusy(seqBusy), .seqDone(seqDone), .seqRefused(seqRefused), .extAddr(extAddr), .extDataIn(extDataIn),
      .extDataOut(extDataOut), .extDataOeN(extDataOeN), .extWrN(extWrN), .extRdN(extRdN),
      .attributePinZero(attributePinZero), .transferAckInputN(taN), .busBusyOutputN(busBusyOutputN));
   fpe_flash_model flash (.core_clk(core_clk), .extAddr(extAddr), .extDataOut(extDataOut),
      .extDataOeN(extDataOeN), .extWrN(extWrN), .extRdN(extRdN), .attributePinZero(attributePinZero),
      .extDataIn(extDataIn));
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic wrapUp;
      if (badCount == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Ceiling well above the longest expected run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         badCount++;
         wrapUp;
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         badCount++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic ioWrite(input logic [23:0] a, input logic [23:0] d);
      @(negedge core_clk);
      ioAddr = a;
      ioWdata = d;
      ioWr = 1'b1;
      @(negedge core_clk);
      ioWr = 1'b0;
   endtask
   task automatic ioRead(input logic [23:0] a, output logic [23:0] d);
      @(negedge core_clk);
      ioAddr = a;
      ioRd = 1'b1;
      @(negedge core_clk);
      ioRd = 1'b0;
      d = ioRdata;
   endtask
   task automatic regCheck(input logic [23:0] a, input logic [23:0] exp);
      logic [23:0] v;
      ioRead(a, v);
      check(v, exp);
   endtask
   task automatic runCmd(input fpe_pkg::fpe_op_type op, input fpe_pkg::fpe_space_type sp,
                         input logic [23:0] a, input logic [23:0] d, input logic refuse);
      logic [23:0] v;
      int          n;
      flash.wrAddr.delete();
      flash.wrData.delete();
      flash.wrPin.delete();
      flash.wrLen.delete();
      @(negedge core_clk);
      cmdOp = op;
      cmdSpace = sp;
      cmdAddr = a;
      cmdData = d;
      cmdStart = 1'b1;
      @(negedge core_clk);
      cmdStart = 1'b0;
      check(24'(seqRefused), 24'(refuse));
      ioRead(Bus_wait_control, v);
      check(24'(v[21]), 24'(!refuse));
      check(24'(seqBusy), 24'(!refuse));
      n = 0;
      while (!refuse && seqDone !== 1'b1 && n < 4000)
      begin
         @(negedge core_clk);
         n++;
      end
      check(24'(seqDone), 24'(!refuse));
      @(negedge core_clk);
      check(24'(busBusyOutputN), 24'(refuse || !slowRel));
      @(negedge core_clk);
      check(24'(busBusyOutputN), 24'h000001);
   endtask
   task automatic checkSeq(input fpe_pkg::fpe_op_type op, input logic [23:0] tgt, input logic [23:0] d);
      logic [23:0] ea [$];
      logic [23:0] ed [$];
      if (op == fpe_pkg::OP_PROGRAM)
      begin
         ea = {Base + 24'h005555, Base + 24'h002aaa, Base + 24'h005555, tgt};
         ed = {24'haaaaaa, 24'h555555, 24'ha0a0a0, d};
      end
      else
      begin
         ea = {Base + 24'h005555, Base + 24'h002aaa, Base + 24'h005555, Base + 24'h005555,
               Base + 24'h002aaa, tgt};
         ed = {24'haaaaaa, 24'h555555, 24'h808080, 24'haaaaaa, 24'h555555, 24'h303030};
      end
      check(24'(flash.wrAddr.size()), 24'(ea.size()));
      foreach (ea[i])
      begin
         check(flash.wrAddr[i], ea[i]);
         check(flash.wrData[i], ed[i]);
      end
   endtask
   task automatic prog(input fpe_pkg::fpe_space_type sp, input logic [23:0] a, input logic [23:0] tgt,
                       input logic pin, input logic upin, input int len);
      runCmd(fpe_pkg::OP_PROGRAM, sp, a, a ^ 24'h0f0f00, 1'b0);
      checkSeq(fpe_pkg::OP_PROGRAM, tgt, a ^ 24'h0f0f00);
      check(24'(flash.wrPin[3]), 24'(pin));
      check(24'(flash.wrPin[0]), 24'(upin));
      check(24'(flash.wrLen[3]), 24'(len));
      check(24'(flash.wrLen[0]), 24'(defLen));
   endtask
   initial
   begin
      repeat (6) @(negedge core_clk);
      sys_rst = 1'b0;
      check(24'(attributePinZero), 24'h000001);
      regCheck(Aar, fpe_pkg::ATTR0_RST);
      regCheck(Bus_wait_control, fpe_pkg::BUSCTL_RST);
      regCheck(Operating_mode_reg, fpe_pkg::OPMODE_RST);
      regCheck(24'hfffffa, 24'h000000);
      prog(fpe_pkg::SPACE_P, 24'h000123, Base + 24'h000123, 1'b1, 1'b1, 2);
      ioWrite(Aar, 24'hc4063d);
      ioWrite(Bus_wait_control, 24'h230005);
      ioWrite(Operating_mode_reg, 24'h004000);
      regCheck(Aar, 24'hc4063d);
      regCheck(Bus_wait_control, 24'h030005);
      regCheck(Operating_mode_reg, 24'h004000);
      defLen = 5;
      for (int s = 0; s < 3; s++)
         prog(fpe_pkg::fpe_space_type'(s), 24'h040000 + 24'(s * 16), Base + 24'h040000 + 24'(s * 16),
              1'b1, 1'b0, 7);
      prog(fpe_pkg::SPACE_P, 24'h07ffff, 24'hc7ffff, 1'b1, 1'b0, 7);
      prog(fpe_pkg::SPACE_P, 24'h03ffff, 24'hc3ffff, 1'b0, 1'b0, 5);
      for (int s = 0; s < 3; s++)
      begin
         ioWrite(Aar, 24'hc4063d & ~(24'h000008 << s));
         prog(fpe_pkg::fpe_space_type'(s), 24'h040100 + 24'(s), Base + 24'h040100 + 24'(s),
              1'b0, 1'b0, 5);
      end
      ioWrite(Aar, 24'hc40639);
      prog(fpe_pkg::SPACE_X, 24'h040200, 24'hc40200, 1'b0, 1'b1, 7);
      ioWrite(Aar, 24'hc4063e);
      prog(fpe_pkg::SPACE_Y, 24'h040300, 24'hc40300, 1'b0, 1'b0, 5);
      ioWrite(Aar, 24'hc4067d);
      prog(fpe_pkg::SPACE_P, 24'h040234, 24'h340234, 1'b1, 1'b0, 7);
      ioWrite(Aar, 24'hc4063d);
      prog(fpe_pkg::SPACE_P, 24'h070010, 24'hc70010, 1'b1, 1'b0, 7);
      // Slow erase so that several polls see it still busy
      flash.busyCycles = 40;
      runCmd(fpe_pkg::OP_ERASE, fpe_pkg::SPACE_P, 24'h07f800, 24'h000000, 1'b0);
      checkSeq(fpe_pkg::OP_ERASE, 24'hc70000, 24'h000000);
      check(flash.mem[19'h70010], 24'hffffff);
      check(flash.mem[19'h40000], 24'h040000 ^ 24'h0f0f00);
      // Ack held off: in synchronised-ack mode the strobe waits for it
      taN = 1'b1;
      slowRel = 1'b1;
      ioWrite(Operating_mode_reg, 24'h005800);
      fork
         runCmd(fpe_pkg::OP_PROGRAM, fpe_pkg::SPACE_P, 24'h070020, 24'h123456, 1'b0);
         begin
            repeat (20) @(negedge core_clk);
            check(24'(extWrN), 24'h000000);
            taN = 1'b0;
         end
      join
      checkSeq(fpe_pkg::OP_PROGRAM, 24'hc70020, 24'h123456);
      slowRel = 1'b0;
      ioWrite(Operating_mode_reg, 24'h004010);
      runCmd(fpe_pkg::OP_PROGRAM, fpe_pkg::SPACE_X, 24'h000400, 24'h000001, 1'b1);
      check(24'(flash.wrAddr.size()), 24'h000000);
      ioWrite(Operating_mode_reg, 24'h004000);
      wrapUp;
   end
endmodule
`default_nettype wire
